// file: verilog/accel_ctrl_pkg.sv
// Package: register map, field positions, reset values and timing for the control register bank
package accel_ctrl_pkg;
   localparam logic [7:0] highpass_filter_control_addr = 8'h21;
   localparam logic [7:0] int_pin1_routing_addr        = 8'h22;
   localparam logic [7:0] data_format_control_addr     = 8'h23;
   localparam logic [7:0] boot_fifo_latch_control_addr = 8'h24;
   localparam logic [7:0] reference_value_reg_addr     = 8'h26;
   localparam logic [7:0] gen1_source_reg_addr         = 8'h31;
   localparam logic [7:0] gen2_source_reg_addr         = 8'h35;

   localparam logic [7:0] highpass_filter_control_rst = 8'h00;
   localparam logic [7:0] int_pin1_routing_rst        = 8'h00;
   localparam logic [7:0] data_format_control_rst     = 8'h00;
   localparam logic [7:0] boot_fifo_latch_control_rst = 8'h00;
   localparam logic [7:0] reference_value_rst         = 8'h00;

   // Writable bits per register; the rest read zero
   localparam logic [7:0] int_pin1_routing_mask        = 8'hfe;
   localparam logic [7:0] boot_fifo_latch_control_mask = 8'hcf;

   // highpass_filter_control fields
   localparam int filter_mode_pos    = 6;
   localparam int filter_cutoff_pos  = 4;
   localparam int filtered_data_pos  = 3;
   localparam int tap_filter_pos     = 2;
   localparam int gen2_filter_pos    = 1;
   localparam int gen1_filter_pos    = 0;
   // int_pin1_routing fields
   localparam int pin1_tap_pos       = 7;
   localparam int pin1_gen1_pos      = 6;
   localparam int pin1_gen2_pos      = 5;
   localparam int pin1_ready_a_pos   = 4;
   localparam int pin1_ready_b_pos   = 3;
   localparam int pin1_watermark_pos = 2;
   localparam int pin1_overflow_pos  = 1;
   // data_format_control fields
   localparam int block_update_pos   = 7;
   localparam int byte_order_pos     = 6;
   localparam int range_pos          = 4;
   localparam int high_res_pos       = 3;
   localparam int selftest_pos       = 1;
   localparam int serial_wire_pos    = 0;
   // boot_fifo_latch_control fields
   localparam int reboot_pos         = 7;
   localparam int fifo_en_pos        = 6;
   localparam int gen1_latch_pos     = 3;
   localparam int gen1_four_dir_pos  = 2;
   localparam int gen2_latch_pos     = 1;
   localparam int gen2_four_dir_pos  = 0;

   localparam logic [1:0] filter_mode_read_reset = 2'h0;
   localparam logic [1:0] filter_mode_reference  = 2'h1;
   localparam logic [1:0] filter_mode_normal     = 2'h2;
   localparam logic [1:0] filter_mode_autoreset  = 2'h3;
   localparam logic [1:0] selftest_undefined     = 2'h3;

   localparam int core_clk_hz  = 25000000;
   localparam int boot_time_ms = 5;
   localparam int boot_cycles  = (core_clk_hz / 1000) * boot_time_ms;
endpackage : accel_ctrl_pkg

// file: verilog/accel_control_registers.sv
// Control register bank: filter, pin routing, data format, boot, FIFO and latch settings
// Notes on behaviour
// [R1] Mode 00 resets filter on reference read
// [R2] Modes: reference, normal, autoreset on interrupt
// [R3] Two-bit cutoff, 00 highest, 11 lowest
// [R4] Filtered-data bit feeds outputs and FIFO
// [R5] Tap-filter bit filters tap detection input
// [R6] Gen2 filter bit filters second generator data
// [R7] Gen1 filter bit filters first generator data
// [R8] Tap, gen and ready events routed to pin
// [R9] Watermark and overrun events routed to pin
// [R10] Block update holds outputs until both read
// [R11] Byte order selects which byte is lower
// [R12] Byte swap only in high-resolution mode
// [R13] Range field selects 2, 4, 8, 16 g
// [R14] Self-test field: normal, variant 0, variant 1
// [R15] Host avoids self-test code 11
// [R16] Serial mode bit: 4-wire or 3-wire
// [R17] Reboot bit reloads boot registers from memory
// [R18] Boot reloads calibration, takes about 5 ms
// [R19] FIFO enable bit enables the FIFO
// [R20] Latch holds request until source read
// [R21] Four-direction only with six-direction enabled
// [R22] Reference register holds eight-bit reference value
// [R23] Unused bits read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
module accel_control_registers #(
   parameter int boot_cycles = accel_ctrl_pkg::boot_cycles
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // Register port from the serial interface
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Event sources, mode and status inputs, output read strobes and boot data
   input  wire logic       tap_event_i,
   input  wire logic       gen1_event_i,
   input  wire logic       gen2_event_i,
   input  wire logic       ready_event_a_i,
   input  wire logic       ready_event_b_i,
   input  wire logic       fifo_watermark_i,
   input  wire logic       fifo_overrun_i,
   input  wire logic       high_res_mode_i,
   input  wire logic       six_dir_enable1_i,
   input  wire logic       six_dir_enable2_i,
   input  wire logic       out_low_read_i,
   input  wire logic       out_high_read_i,
   input  wire logic       new_sample_i,
   input  wire logic [7:0] boot_data_i,
   // Control outputs
   output logic            irq_pin_a_o,
   output logic            filter_reset_o,
   output logic [1:0]      filter_mode_sel_o,
   output logic [1:0]      filter_cutoff_sel_o,
   output logic            filtered_data_sel_o,
   output logic            tap_filter_en_o,
   output logic            gen1_filter_en_o,
   output logic            gen2_filter_en_o,
   output logic            output_update_o,
   output logic            byte_swap_o,
   output logic [1:0]      range_sel_o,
   output logic            high_res_sel_o,
   output logic [1:0]      selftest_sel_o,
   output logic            serial_wire_mode_o,
   output logic            boot_busy_o,
   output logic            boot_load_o,
   output logic            fifo_en_o,
   output logic            gen1_irq_o,
   output logic            gen2_irq_o,
   output logic            gen1_four_dir_o,
   output logic            gen2_four_dir_o,
   output logic [7:0]      reference_value_o
);
   initial begin
      if (boot_cycles < 1) $error("boot_cycles must be at least one");
   end

   localparam int cw = $clog2(boot_cycles + 1);

   typedef enum {boot_idle_st, boot_run_st} boot_state_type;

   typedef struct packed {
      logic [7:0]     hpf;
      logic [7:0]     route;
      logic [7:0]     fmt;
      logic [7:0]     bflc;
      logic [7:0]     ref_val;
      logic [7:0]     rdata;
      logic           irq;
      logic           filt_rst;
      logic           upd;
      logic           low_seen;
      logic           high_seen;
      logic           pend;
      logic           g1_irq;
      logic           g2_irq;
      boot_state_type bst;
      logic [cw-1:0]  bcnt;
      logic           bload;
   } state_type;

   state_type st;
   state_type next_st;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic wr_hit;
      logic [7:0] route_mask;
      wr_hit = 1'b0;
      route_mask = accel_ctrl_pkg::int_pin1_routing_mask;
      next_st = st;
      next_st.filt_rst = 1'b0;
      next_st.bload = 1'b0;

      if (reg_wr_i) begin
         wr_hit = 1'b1;
         case (reg_addr_i)
            accel_ctrl_pkg::highpass_filter_control_addr: next_st.hpf = reg_wdata_i;
            accel_ctrl_pkg::int_pin1_routing_addr: next_st.route = reg_wdata_i & route_mask; // [R23]
            accel_ctrl_pkg::data_format_control_addr: next_st.fmt = reg_wdata_i;
            accel_ctrl_pkg::boot_fifo_latch_control_addr:
               next_st.bflc = reg_wdata_i & accel_ctrl_pkg::boot_fifo_latch_control_mask; // [R23]
            accel_ctrl_pkg::reference_value_reg_addr: next_st.ref_val = reg_wdata_i; // [R22]
            default: wr_hit = 1'b0;
         endcase
      end

      // Read data; unmapped and unused bits read zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            accel_ctrl_pkg::highpass_filter_control_addr: next_st.rdata = st.hpf;
            accel_ctrl_pkg::int_pin1_routing_addr: next_st.rdata = st.route;
            accel_ctrl_pkg::data_format_control_addr: next_st.rdata = st.fmt;
            accel_ctrl_pkg::boot_fifo_latch_control_addr: next_st.rdata = st.bflc;
            accel_ctrl_pkg::reference_value_reg_addr: next_st.rdata = st.ref_val;
            default: next_st.rdata = 8'h00;
         endcase
      end

      // Filter reset on reference read in mode 00, or on interrupt in autoreset
      if (reg_rd_i && reg_addr_i == accel_ctrl_pkg::reference_value_reg_addr &&
          st.hpf[accel_ctrl_pkg::filter_mode_pos +: 2] == accel_ctrl_pkg::filter_mode_read_reset) begin
         next_st.filt_rst = 1'b1; // [R1]
      end
      if (st.hpf[accel_ctrl_pkg::filter_mode_pos +: 2] == accel_ctrl_pkg::filter_mode_autoreset &&
          (gen1_event_i || gen2_event_i)) begin
         next_st.filt_rst = 1'b1; // [R2]
      end

      // Interrupt pin A: OR of enabled sources
      next_st.irq = (st.route[accel_ctrl_pkg::pin1_tap_pos] & tap_event_i) |
                    (st.route[accel_ctrl_pkg::pin1_gen1_pos] & st.g1_irq) |
                    (st.route[accel_ctrl_pkg::pin1_gen2_pos] & st.g2_irq) |
                    (st.route[accel_ctrl_pkg::pin1_ready_a_pos] & ready_event_a_i) |
                    (st.route[accel_ctrl_pkg::pin1_ready_b_pos] & ready_event_b_i) | // [R8]
                    (st.route[accel_ctrl_pkg::pin1_watermark_pos] & fifo_watermark_i) |
                    (st.route[accel_ctrl_pkg::pin1_overflow_pos] & fifo_overrun_i); // [R9]

      // Generator requests: latched ones wait for a source read; set beats clear
      if (st.bflc[accel_ctrl_pkg::gen1_latch_pos]) begin
         if (reg_rd_i && reg_addr_i == accel_ctrl_pkg::gen1_source_reg_addr) next_st.g1_irq = 1'b0; // [R20]
         if (gen1_event_i) next_st.g1_irq = 1'b1;
      end else begin
         next_st.g1_irq = gen1_event_i;
      end
      if (st.bflc[accel_ctrl_pkg::gen2_latch_pos]) begin
         if (reg_rd_i && reg_addr_i == accel_ctrl_pkg::gen2_source_reg_addr) next_st.g2_irq = 1'b0; // [R20]
         if (gen2_event_i) next_st.g2_irq = 1'b1;
      end else begin
         next_st.g2_irq = gen2_event_i;
      end

      // Block update: hold refresh from first byte read until the pair is done
      if (!st.fmt[accel_ctrl_pkg::block_update_pos]) begin
         next_st.upd = new_sample_i; // [R10]
         next_st.low_seen = 1'b0;
         next_st.high_seen = 1'b0;
         next_st.pend = 1'b0;
      end else begin
         if (out_low_read_i) next_st.low_seen = 1'b1;
         if (out_high_read_i) next_st.high_seen = 1'b1;
         if (new_sample_i) next_st.pend = 1'b1;
         next_st.upd = 1'b0;
         if ((st.low_seen == st.high_seen) && (st.pend || new_sample_i)) begin
            next_st.upd = 1'b1; // [R10]
            next_st.pend = 1'b0;
            next_st.low_seen = 1'b0;
            next_st.high_seen = 1'b0;
         end
      end

      // Reboot sequence: reload calibration after the boot time
      case (st.bst)
         boot_idle_st: begin
            if (st.bflc[accel_ctrl_pkg::reboot_pos]) begin
               next_st.bst = boot_run_st; // [R17]
               next_st.bcnt = cw'(boot_cycles);
            end
         end
         boot_run_st: begin
            if (st.bcnt == cw'(1)) begin
               next_st.bst = boot_idle_st;
               next_st.bload = 1'b1; // [R18]
               next_st.bflc[accel_ctrl_pkg::reboot_pos] = 1'b0;
            end else begin
               next_st.bcnt = st.bcnt - cw'(1);
            end
         end
         default: next_st.bst = boot_idle_st;
      endcase
      if (wr_hit && st.bst == boot_run_st) begin
         next_st.bflc[accel_ctrl_pkg::reboot_pos] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
         st.hpf <= accel_ctrl_pkg::highpass_filter_control_rst; // [R1]
         st.route <= accel_ctrl_pkg::int_pin1_routing_rst;
         st.fmt <= accel_ctrl_pkg::data_format_control_rst;
         st.bflc <= accel_ctrl_pkg::boot_fifo_latch_control_rst;
         st.ref_val <= accel_ctrl_pkg::reference_value_rst;
         st.bst <= boot_idle_st;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs from flip-flops; the four-direction outputs are also gated by the six-direction inputs
   // ----------------------------------------------------------------
   assign reg_rdata_o = st.rdata;
   assign irq_pin_a_o = st.irq;
   assign filter_reset_o = st.filt_rst;
   assign filter_mode_sel_o = st.hpf[accel_ctrl_pkg::filter_mode_pos +: 2]; // [R2]
   assign filter_cutoff_sel_o = st.hpf[accel_ctrl_pkg::filter_cutoff_pos +: 2]; // [R3]
   assign filtered_data_sel_o = st.hpf[accel_ctrl_pkg::filtered_data_pos]; // [R4]
   assign tap_filter_en_o = st.hpf[accel_ctrl_pkg::tap_filter_pos]; // [R5]
   assign gen2_filter_en_o = st.hpf[accel_ctrl_pkg::gen2_filter_pos]; // [R6]
   assign gen1_filter_en_o = st.hpf[accel_ctrl_pkg::gen1_filter_pos]; // [R7]
   assign output_update_o = st.upd;
   // Swap only honoured while the high-resolution bit is set
   assign byte_swap_o = st.fmt[accel_ctrl_pkg::byte_order_pos] & st.fmt[accel_ctrl_pkg::high_res_pos]; // [R11] [R12]
   assign range_sel_o = st.fmt[accel_ctrl_pkg::range_pos +: 2]; // [R13]
   assign high_res_sel_o = st.fmt[accel_ctrl_pkg::high_res_pos];
   // Undefined code is shown as normal operation
   assign selftest_sel_o = (st.fmt[accel_ctrl_pkg::selftest_pos +: 2] == accel_ctrl_pkg::selftest_undefined) ?
                           2'h0 : st.fmt[accel_ctrl_pkg::selftest_pos +: 2]; // [R14] [R15]
   assign serial_wire_mode_o = st.fmt[accel_ctrl_pkg::serial_wire_pos]; // [R16]
   assign boot_busy_o = st.bflc[accel_ctrl_pkg::reboot_pos];
   assign boot_load_o = st.bload; // [R18]
   assign fifo_en_o = st.bflc[accel_ctrl_pkg::fifo_en_pos]; // [R19]
   assign gen1_irq_o = st.g1_irq;
   assign gen2_irq_o = st.g2_irq;
   assign gen1_four_dir_o = st.bflc[accel_ctrl_pkg::gen1_four_dir_pos] & six_dir_enable1_i; // [R21]
   assign gen2_four_dir_o = st.bflc[accel_ctrl_pkg::gen2_four_dir_pos] & six_dir_enable2_i; // [R21]
   assign reference_value_o = st.ref_val; // [R22]

   logic unused_ok;
   assign unused_ok = high_res_mode_i ^ (^boot_data_i);
endmodule : accel_control_registers
`default_nettype wire

// file: testbench/accel_control_registers_sva.sv
// Concurrent checks on the control register bank ports
`timescale 1ns/10ps
`default_nettype none
module accel_control_registers_sva #(
   parameter int boot_cycles = 4
) (
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       gen1_event_i,
   input wire logic       gen2_event_i,
   input wire logic       filter_reset_o,
   input wire logic [1:0] filter_mode_sel_o,
   input wire logic       byte_swap_o,
   input wire logic       high_res_sel_o,
   input wire logic [1:0] selftest_sel_o,
   input wire logic       boot_busy_o,
   input wire logic       boot_load_o
);
   int busy_cnt;
   always_ff @(posedge core_clk_i) begin
      busy_cnt <= boot_busy_o ? busy_cnt + 1 : 0;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // -----------------------------------------------------------------
   // Sequences
   // -----------------------------------------------------------------
   sequence s_ref_read;
      reg_rd_i && reg_addr_i == accel_ctrl_pkg::reference_value_reg_addr && filter_mode_sel_o == 2'h0;
   endsequence
   sequence s_gen_event;
      filter_mode_sel_o == 2'h3 && (gen1_event_i || gen2_event_i);
   endsequence
   sequence s_read_of(logic [7:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_ref_read_reset: assert property (s_ref_read |=> filter_reset_o) else $error("no filter reset on read");
   a_auto_reset: assert property (s_gen_event |=> filter_reset_o) else $error("no autoreset");
   a_unmapped_zero: assert property (s_read_of(8'h25) |=> reg_rdata_o == 8'h00) else $error("unmapped nonzero");
   a_routing_bit0: assert property (s_read_of(8'h22) |=> !reg_rdata_o[0]) else $error("spare bit set");
   a_boot_spare: assert property (s_read_of(8'h24) |=> reg_rdata_o[5:4] == 2'h0) else $error("spare bits set");
   a_swap_hr_only: assert property (byte_swap_o |-> high_res_sel_o) else $error("swap outside high res");
   a_selftest_code: assert property (selftest_sel_o != 2'h3) else $error("undefined self-test out");
   a_boot_load: assert property ($fell(boot_busy_o) |-> ##[0:1] boot_load_o) else $error("no boot load");
   a_boot_length: assert property ($fell(boot_busy_o) |-> busy_cnt >= boot_cycles - 1 && busy_cnt <= boot_cycles + 1)
      else $error("boot length off");
endmodule : accel_control_registers_sva
bind accel_control_registers accel_control_registers_sva #(.boot_cycles(boot_cycles)) u_sva (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_rdata_o(reg_rdata_o), .gen1_event_i(gen1_event_i), .gen2_event_i(gen2_event_i),
   .filter_reset_o(filter_reset_o), .filter_mode_sel_o(filter_mode_sel_o), .byte_swap_o(byte_swap_o),
   .high_res_sel_o(high_res_sel_o), .selftest_sel_o(selftest_sel_o), .boot_busy_o(boot_busy_o),
   .boot_load_o(boot_load_o));
`default_nettype wire

// file: testbench/host_bus_model.sv
// Host model issuing register reads and writes on the register port
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output var  logic       reg_wr_o,
   output var  logic       reg_rd_o,
   output var  logic [7:0] reg_addr_o,
   output var  logic [7:0] reg_wdata_o
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // Data comes from the caller; self-test 11 only when a scenario asks
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data, output logic [7:0] q);
      @(posedge core_clk_i);
      reg_wr_o <= wr;
      reg_rd_o <= !wr;
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      // Released lines show no stale value
      reg_addr_o <= ~addr;
      reg_wdata_o <= ~data;
      #1;
      q = reg_rdata_i;
   endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// file: testbench/accel_control_registers_test.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
`default_nettype none
module accel_control_registers_test;
   localparam int boot_len = 4;
   logic       core_clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic [7:1] ev = 7'h00;
   logic [2:0] ctl = 3'h0;
   logic [1:0] six = 2'h0;
   logic [7:0] q;
   int         fails = 0;
   int         comparisons = 0;
   int         upd = 0;
   int         loads = 0;
   wire logic  wr, rd, irq, filtered_data_sel, tapf, g1f, g2f, update, swap, hr, ser, busy, load, fifo, g1i, g2i, g1d, g2d, frst;
   wire logic [1:0] mode, cut, range, st;
   wire logic [7:0] addr, wdata, rdata, refv;
   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      upd += (update === 1'b1);
      loads += (load === 1'b1);
   end
   host_bus_model u_host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_addr_o(addr), .reg_wdata_o(wdata));
   accel_control_registers #(.boot_cycles(boot_len)) u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .tap_event_i(ev[7]), .gen1_event_i(ev[6]), .gen2_event_i(ev[5]), .ready_event_a_i(ev[4]),
      .ready_event_b_i(ev[3]), .fifo_watermark_i(ev[2]), .fifo_overrun_i(ev[1]), .high_res_mode_i(1'b0),
      .six_dir_enable1_i(six[1]), .six_dir_enable2_i(six[0]), .out_low_read_i(ctl[0]), .out_high_read_i(ctl[1]),
      .new_sample_i(ctl[2]), .boot_data_i(8'h00), .irq_pin_a_o(irq), .filter_reset_o(frst), .filter_mode_sel_o(mode),
      .filter_cutoff_sel_o(cut), .filtered_data_sel_o(filtered_data_sel), .tap_filter_en_o(tapf), .gen1_filter_en_o(g1f),
      .gen2_filter_en_o(g2f), .output_update_o(update), .byte_swap_o(swap), .range_sel_o(range),
      .high_res_sel_o(hr), .selftest_sel_o(st), .serial_wire_mode_o(ser), .boot_busy_o(busy),
      .boot_load_o(load), .fifo_en_o(fifo), .gen1_irq_o(g1i), .gen2_irq_o(g2i), .gen1_four_dir_o(g1d),
      .gen2_four_dir_o(g2d), .reference_value_o(refv));
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : cyc
   task automatic pulse(input int i);
      @(posedge core_clk_i);
      ctl[i] <= 1'b1;
      @(posedge core_clk_i);
      ctl[i] <= 1'b0;
      #1;
   endtask : pulse
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset_and_rw();
      logic [7:0] a [6];
      logic [7:0] w [6];
      logic [7:0] e [6];
      a = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
      w = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'ha5};
      e = '{8'hff, 8'hfe, 8'hff, 8'h4f, 8'h00, 8'ha5};
      foreach (a[i]) begin
         u_host.xfer(1'b0, a[i], 8'h00, q);
         check("reset", q, 8'h00);
         u_host.xfer(1'b1, a[i], w[i], q);
         u_host.xfer(1'b0, a[i], 8'h00, q);
         check("readback", q, e[i]);
      end
      check("filter", {mode, cut, filtered_data_sel, tapf, g2f, g1f}, 8'hff);
      check("format", {1'b0, swap, range, hr, st, ser}, 8'h79);
      check("fifo_ref", {fifo, refv[6:0]}, 8'ha5);
   endtask : t_reset_and_rw
   task automatic t_format();
      for (int c = 0; c < 4; c++) begin
         u_host.xfer(1'b1, 8'h23, {2'h1, c[1:0], 1'b0, c[1:0], 1'b0}, q);
         u_host.xfer(1'b0, 8'h23, 8'h00, q);
         check("fmt_rb", q, {2'h1, c[1:0], 1'b0, c[1:0], 1'b0});
         check("fmt", {1'b0, swap, range, hr, st, ser},
               {2'h0, c[1:0], 1'b0, (c == 3) ? 2'h0 : c[1:0], 1'b0});
      end
      u_host.xfer(1'b1, 8'h23, 8'h48, q);
      check("swap_hr", {7'h00, swap}, 8'h01);
   endtask : t_format
   task automatic t_routing();
      u_host.xfer(1'b1, 8'h24, 8'h00, q);
      for (int b = 1; b < 8; b++) begin
         u_host.xfer(1'b1, 8'h22, 8'h01 << b, q);
         @(posedge core_clk_i);
         ev <= ~(7'h01 << (b - 1));
         cyc(4);
         check("irq_masked", {7'h00, irq}, 8'h00);
         ev <= 7'h01 << (b - 1);
         cyc(4);
         check("irq_routed", {7'h00, irq}, 8'h01);
         ev <= 7'h00;
         cyc(4);
         check("irq_unlatched", {7'h00, irq}, 8'h00);
      end
   endtask : t_routing
   task automatic t_latch_and_dir();
      u_host.xfer(1'b1, 8'h24, 8'h0f, q);
      @(posedge core_clk_i);
      ev <= 7'h30;
      six <= 2'h1;
      @(posedge core_clk_i);
      ev <= 7'h00;
      cyc(3);
      check("latched", {4'h0, g1i, g2i, g1d, g2d}, 8'h0d);
      u_host.xfer(1'b0, 8'h35, 8'h00, q);
      @(posedge core_clk_i);
      six <= 2'h2;
      cyc(1);
      check("gen2_clear", {4'h0, g1i, g2i, g1d, g2d}, 8'h0a);
      u_host.xfer(1'b0, 8'h31, 8'h00, q);
      check("gen1_clear", {6'h00, g1i, g2i}, 8'h00);
   endtask : t_latch_and_dir
   task automatic t_block_update();
      int n;
      u_host.xfer(1'b1, 8'h23, 8'h80, q);
      n = upd;
      pulse(0);
      pulse(2);
      cyc(3);
      check("held", 8'(upd - n), 8'h00);
      pulse(1);
      cyc(3);
      check("released", 8'(upd - n), 8'h01);
      u_host.xfer(1'b1, 8'h23, 8'h00, q);
      pulse(2);
      cyc(2);
      check("continuous", 8'(upd - n), 8'h02);
   endtask : t_block_update
   task automatic t_filter_reset();
      u_host.xfer(1'b1, 8'h21, 8'h00, q);
      u_host.xfer(1'b0, 8'h26, 8'h00, q);
      check("ref_read_reset", {7'h00, frst}, 8'h01);
      cyc(1);
      check("reset_pulse_end", {7'h00, frst}, 8'h00);
      u_host.xfer(1'b1, 8'h21, 8'h80, q);
      u_host.xfer(1'b0, 8'h26, 8'h00, q);
      check("normal_no_reset", {7'h00, frst}, 8'h00);
   endtask : t_filter_reset
   task automatic t_boot();
      int n;
      n = loads;
      u_host.xfer(1'b1, 8'h24, 8'h80, q);
      check("busy", {7'h00, busy}, 8'h01);
      cyc(boot_len + 4);
      check("boot_done", {busy, 7'(loads - n)}, 8'h01);
      u_host.xfer(1'b0, 8'h24, 8'h00, q);
      check("boot_clear", q, 8'h00);
   endtask : t_boot
   task automatic stop_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (5000) @(posedge core_clk_i);
      fails++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_reset_and_rw();
      t_format();
      t_routing();
      t_latch_and_dir();
      t_block_update();
      t_filter_reset();
      t_boot();
      stop_test();
   end
endmodule : accel_control_registers_test
`default_nettype wire
